// >>> bench/roc_pin_tester.sv
// board tester model: sends bursts of rising edges on the clock pin
// assumes the bench pulls the pin up whenever drive_en is low
`timescale 1ns/1ps
module roc_pin_tester (
   // clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // burst request
   input  wire       go,
   input  wire [7:0] n_edges,
   output logic      busy,
   // pin drive
   output logic      drive_en,
   output logic      level
);
   logic [7:0] left;
   logic [2:0] ph;
   // four cycles low, four high: above the three-cycle sync minimum
   always @(posedge aclk) begin
      if (!aresetn || !busy) begin
         busy     <= aresetn && go;
         drive_en <= aresetn && go;
         level    <= !(aresetn && go);
         left     <= n_edges;
         ph       <= 3'h0;
      end else begin
         ph <= ph + 3'h1;
         if (ph == 3'h3)
            level <= 1'b1;
         if (ph == 3'h7 && left == 8'h1) begin
            busy     <= 1'b0;
            drive_en <= 1'b0;
         end else if (ph == 3'h7) begin
            left  <= left - 8'h1;
            level <= 1'b0;
         end
      end
   end
endmodule

// >>> bench/roc_props.sv
// checker for the rtc time base, watching top-level ports only
// assumes it is bound into roc_top and BASE_DIV matches the instance
`timescale 1ns/1ps
module roc_props #(
   parameter BASE_DIV = 16
) (
   // clock and reset
   input wire        aclk,
   input wire        aresetn,
   // register bus
   input wire [7:0]  s_axi_awaddr,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // pin and time base
   input wire        clock_out_pin_o,
   input wire        clock_out_pin_oe_n,
   input wire        tick_1hz,
   input wire        tick_64hz
);
   logic        tmode;
   logic        seen;
   logic [31:0] gap;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // shadow of the test select bit, taken from control writes
   always @(posedge aclk) begin
      if (!aresetn) begin
         tmode <= 1'b0;
         seen  <= 1'b0;
         gap   <= 32'h0;
      end else begin
         if (s_axi_awready && s_axi_wready && s_axi_awaddr == 8'h00)
            tmode <= s_axi_wdata[1];
         gap  <= tick_64hz ? 32'h0 : gap + 32'h1;
         seen <= seen | tick_64hz;
      end
   end
   sequence s_wtake;
      s_axi_awready && s_axi_wready;
   endsequence
   sequence s_bwait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   pin_low_a: assert property (clock_out_pin_o == 1'b0) else $error("pin data not low");
   test_oe_a: assert property (tmode && $past(tmode) |-> clock_out_pin_oe_n)
      else $error("pin driven in test mode");
   base_gap_a: assert property (tick_64hz && seen |-> gap == BASE_DIV - 1)
      else $error("base tick spacing wrong");
   aw_w_a: assert property (s_axi_awready |-> s_axi_wready) else $error("aw and w split");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready long");
   wr_resp_a: assert property (s_wtake |=> s_axi_bvalid) else $error("no write response");
   b_hold_a: assert property (s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bvalid dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rvalid dropped");
   rd_resp_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read data");
   b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write during resp");
   tick_pulse_a: assert property (tick_1hz |=> !tick_1hz) else $error("second tick long");
endmodule

// >>> bench/roc_top_tb.sv
// self-checking bench for roc_top: register bus, test clock mode, interrupt
// assumes shortened dividers; the pin is pulled up when nobody drives it
`timescale 1ns/1ps
`include "roc_defines.vh"
module roc_top_tb;
   localparam BD = 16;
   localparam MD = 8;
   logic aclk = 0, aresetn = 0, go = 0, busy, den, lvl;
   logic [7:0]  awaddr = 0, araddr = 0, n_edges = 0;
   logic [31:0] wdata = 0, rdata, d, t, seed = 32'hf96d1efb;
   logic [1:0]  bresp, rresp, r;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, pin_o, oe_n, t1, t64, irq;
   wire  pin = (oe_n === 1'b0) ? 1'b0 : (den === 1'b1 ? lvl : 1'b1);
   int fail_count = 0, tests_run = 0, irq_hi = 0, h0, i;
   always #25 aclk = ~aclk;
   always @(posedge aclk) if (irq === 1'b1) irq_hi <= irq_hi + 1;
   roc_top #(.BASE_DIV(BD), .MON_DIV(MD)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .clock_out_pin_i(pin), .clock_out_pin_o(pin_o), .clock_out_pin_oe_n(oe_n),
      .tick_1hz(t1), .tick_64hz(t64), .irq(irq));
   roc_pin_tester u_pin (.aclk(aclk), .aresetn(aresetn), .go(go), .n_edges(n_edges),
      .busy(busy), .drive_en(den), .level(lvl));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // one second later, hours kept below 23 by the caller
   function automatic logic [31:0] tadd(input logic [31:0] v);
      if (v[5:0] != 6'd59) return v + 32'h1;
      if (v[13:8] != 6'd59) return {v[31:14], v[13:8] + 6'h1, 8'h0};
      return {v[31:21], v[20:16] + 5'h1, 16'h0};
   endfunction
   task automatic stop_test;
      $display("mismatches %0d of %0d compares", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic hang;
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      stop_test();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 0;
         if (wready === 1'b1) wvalid <= 0;
      end while (bvalid !== 1'b1 && n < 99);
      if (n >= 99) hang();
      rs = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 0;
      end while (rvalid !== 1'b1 && n < 99);
      if (n >= 99) hang();
      v = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   task automatic edges(input logic [7:0] k);
      int n;
      @(posedge aclk);
      go <= 1; n_edges <= k;
      @(posedge aclk);
      go <= 0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (busy !== 1'b0 && n < 3000);
      if (n >= 3000) hang();
      repeat (4) @(posedge aclk);
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, r);
      chk({30'h0, r}, 32'h0);
   endtask
   task automatic tchk(input logic [31:0] exp);
      rd(`ROC_REG_TIME, d, r);
      chk(d, exp);
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      for (i = 0; i < 20; i += 4) begin
         if (i == 8) continue;
         rd(i[7:0], d, r);
         chk(d, 32'h0);
      end
      rd(8'h14, d, r);
      chk({d[29:0], r}, 32'h2);
      wr(8'h18, 32'h1, r);
      chk({30'h0, r}, 32'h2);
      for (i = 0; i < 4; i++) begin
         seed = xs(seed);
         wchk(`ROC_REG_OFFSET, seed);
         rd(`ROC_REG_OFFSET, d, r);
         chk(d, seed & 32'h7f);
      end
      wchk(`ROC_REG_OFFSET, 32'h0);
      wchk(`ROC_REG_CTRL, 32'h2);
      @(posedge aclk);
      chk(oe_n, 1'b1);
      wchk(`ROC_REG_CTRL, 32'h3);
      wchk(`ROC_REG_CTRL, 32'h2);
      seed = xs(seed);
      t = {11'h0, seed[20:16] % 5'd23, 2'h0, seed[13:8] % 6'd60, 2'h0, seed[5:0] % 6'd60};
      wchk(`ROC_REG_TIME, t);
      edges(32);
      tchk(tadd(t));
      edges(63);
      tchk(tadd(t));
      edges(1);
      t = tadd(tadd(t));
      tchk(t);
      wchk(`ROC_REG_CTRL, 32'h3);
      edges(64);
      tchk(t);
      wchk(`ROC_REG_CTRL, 32'h2);
      edges(32);
      t = tadd(t);
      tchk(t);
      wchk(`ROC_REG_STATUS, 32'h7);
      wchk(`ROC_REG_MASK, 32'h2);
      chk(irq, 1'b0);
      edges(64);
      chk(irq, 1'b1);
      wchk(`ROC_REG_STATUS, 32'h2);
      @(posedge aclk);
      chk(irq, 1'b0);
      wchk(`ROC_REG_MASK, 32'h0);
      wchk(`ROC_REG_CTRL, 32'hf);
      wchk(`ROC_REG_OFFSET, 32'h1);
      wchk(`ROC_REG_CTRL, 32'he);
      wchk(`ROC_REG_TIME, 32'h3b3b);
      edges(32);
      h0 = irq_hi;
      edges(62);
      tchk(32'h10000);
      edges(1);
      tchk(32'h10001);
      chk(irq_hi - h0, MD);
      rd(`ROC_REG_STATUS, d, r);
      chk(d & 32'h1, 32'h1);
      // five to apply in coarse mode: one in minute 0, the rest dumped into minute 59
      wchk(`ROC_REG_OFFSET, 32'h5);
      wchk(`ROC_REG_TIME, 32'h3b3b);
      edges(64);
      tchk(32'h10000);
      h0 = irq_hi;
      wchk(`ROC_REG_TIME, 32'h13a3b);
      edges(63);
      tchk(32'h13b00);
      // four back-to-back monitor pulses merge into one long high stretch
      edges(4);
      repeat (2 * MD) @(posedge aclk);
      chk(irq_hi - h0, 5 * MD);
      stop_test();
   end
endmodule
bind roc_top roc_props #(.BASE_DIV(BASE_DIV)) u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe_n(clock_out_pin_oe_n),
   .tick_1hz(tick_1hz), .tick_64hz(tick_64hz));

// >>> src/roc_count.v
// one modulo counter of the calendar chain with step, load and wrap
// assumes step and load come from logic on aclk
`timescale 1ns/1ps
module roc_count #(
   parameter         W    = 6,
   parameter [W-1:0] LAST = 6'h3b
) (
   // clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // control
   input  wire         step,
   input  wire         load,
   input  wire [W-1:0] load_val,
   // state
   output reg  [W-1:0] value,
   output wire         wrap
);

   assign wrap = step && (value == LAST);

   always @(posedge aclk) begin
      if (!aresetn) begin
         value <= {W{1'b0}};
      end else if (load) begin
         value <= load_val;
      end else if (wrap) begin
         value <= {W{1'b0}};
      end else if (step) begin
         value <= value + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// >>> src/roc_defines.vh
// constants for the offset-corrected rtc time base: register map, fields, timing
// assumes a 32-bit axi4-lite register bus and a 20 mhz system clock
`ifndef ROC_DEFINES_VH
`define ROC_DEFINES_VH

// register byte offsets
`define ROC_REG_CTRL        8'h00
`define ROC_REG_OFFSET      8'h04
`define ROC_REG_TIME        8'h08
`define ROC_REG_STATUS      8'h0c
`define ROC_REG_MASK        8'h10

// control fields
`define ROC_CTRL_STOP       0
`define ROC_CTRL_EXTERNAL_CLOCK_TEST_SELECT   1
`define ROC_CTRL_CIE        2
`define ROC_CTRL_COARSE     3
`define ROC_CTRL_W          4

// time fields
`define ROC_TIME_SEC_LSB    0
`define ROC_TIME_MIN_LSB    8
`define ROC_TIME_HOUR_LSB   16

// status and mask fields
`define ROC_ST_CORR         0
`define ROC_ST_SEC          1
`define ROC_ST_MIN          2
`define ROC_ST_W            3

// reset values
`define ROC_CTRL_RST        4'h0
`define ROC_OFFSET_RST      7'h00
`define ROC_MASK_RST        3'h0

// timing
`define ROC_CLK_HZ          20000000
`define ROC_BASE_HZ         64
`define ROC_MON_HZ          128
`define ROC_PRESC_BITS      6
`define ROC_LAST_MINUTE     59

`endif

// >>> src/roc_top.v
// offset-corrected rtc time base with external clock test mode and axi4-lite registers
// assumes the board tester drives the clock pin only while test mode is selected
//
// Contract
// - coarse: one pulse per minute in minutes 0-58; 61..64 give 2..5 in minute 59
// - with monitor enable, a 1/128 s interrupt pulse per applied correction
// - several corrections in a minute repeat monitor pulses every 1/64 s
// - correction touches the 1 hz clock only, faster rates untouched
// - setting external test select turns the clock pin into an input
// - test mode clocks the prescaler from the pin, 64 edges per second
// - test clock divided to 1 hz by a six-stage binary prescaler
// - stop clears the prescaler and holds it until stop is cleared
// - after stop release the first second comes at 32 edges, then every 64
// - test mode entry is not aligned to the 64 hz base; prescaler undefined
// - correction inserts or removes one 64 hz step, changing one second
// - coarse correction triggered hourly, one pulse per minute up to 60 minutes
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "roc_defines.vh"
module roc_top #(
   parameter BASE_DIV = `ROC_CLK_HZ / `ROC_BASE_HZ,
   parameter MON_DIV  = `ROC_CLK_HZ / `ROC_MON_HZ
) (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // clock pin, open drain
   input  wire        clock_out_pin_i,
   output reg         clock_out_pin_o,
   output reg         clock_out_pin_oe_n,
   // time base outputs
   output reg         tick_1hz,
   output reg         tick_64hz,
   // interrupt
   output reg         irq
);

   localparam [31:0] BASE_LAST = BASE_DIV - 1;
   localparam [31:0] MON_LAST  = MON_DIV - 1;
   localparam        PW        = `ROC_PRESC_BITS;

   // registers
   reg [`ROC_CTRL_W-1:0] ctrl;
   reg [6:0]             offset;
   reg [`ROC_ST_W-1:0]   status;
   reg [`ROC_ST_W-1:0]   mask;

   wire stop_bit   = ctrl[`ROC_CTRL_STOP];
   wire external_clock_test_select   = ctrl[`ROC_CTRL_EXTERNAL_CLOCK_TEST_SELECT];
   wire correction_monitor_irq_enable        = ctrl[`ROC_CTRL_CIE];
   wire coarse     = ctrl[`ROC_CTRL_COARSE];

   // pin synchroniser and edge detect
   reg pin_meta;
   reg pin_sync;
   reg pin_last;

   always @(posedge aclk) begin
      if (!aresetn) begin
         // the pin idles high on its pull-up; a low reset value would fake an edge
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
         pin_last <= 1'b1;
      end else begin
         pin_meta <= clock_out_pin_i;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   wire pin_rise = pin_sync && !pin_last;

   // internal 64 hz base, never corrected so it can feed fast timer sources
   reg [31:0] base_cnt;
   wire       base_en = (base_cnt == BASE_LAST);

   always @(posedge aclk) begin
      if (!aresetn) begin
         base_cnt <= 32'h0000_0000;
      end else if (base_en) begin
         base_cnt <= 32'h0000_0000;
      end else begin
         base_cnt <= base_cnt + 32'h0000_0001;
      end
   end

   // test mode swaps the step source with no alignment to the internal base
   wire step_src = external_clock_test_select ? pin_rise : base_en;

   // correction scheduling state
   reg [6:0] corr_left;
   reg [6:0] burst_left;
   reg       corr_neg;
   reg       corr_sign_pend;
   reg       new_minute;

   // prescaler: six binary stages, 1 hz tick on the 0 to 1 edge of the top stage
   reg  [PW-1:0] presc;
   reg  [PW-1:0] next_presc;
   reg           corr_apply;

   always @* begin
      next_presc = presc;
      corr_apply = 1'b0;
      if (step_src) begin
         if (burst_left != 7'h00) begin
            corr_apply = 1'b1;
            if (corr_neg) begin
               next_presc = presc;
            end else begin
               next_presc = presc + {{(PW-2){1'b0}}, 2'b10};
            end
         end else begin
            next_presc = presc + {{(PW-1){1'b0}}, 1'b1};
         end
      end
   end

   // cleared prescaler needs half its range to raise the top stage: 32 steps first
   wire sec_tick = !stop_bit && !presc[PW-1] && next_presc[PW-1];

   always @(posedge aclk) begin
      if (!aresetn) begin
         presc <= {PW{1'b0}};
      end else if (stop_bit) begin
         presc <= {PW{1'b0}};
      end else begin
         presc <= next_presc;
      end
   end

   // calendar chain
   wire [5:0] sec;
   wire [5:0] min;
   wire [4:0] hour;
   wire       sec_wrap;
   wire       min_wrap;
   reg        time_load;
   reg [31:0] time_val;

   roc_count #(.W(6), .LAST(6'h3b)) u_sec (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .step     (sec_tick),
      .load     (time_load),
      .load_val (time_val[`ROC_TIME_SEC_LSB +: 6]),
      .value    (sec),
      .wrap     (sec_wrap)
   );

   roc_count #(.W(6), .LAST(6'h3b)) u_min (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .step     (sec_wrap),
      .load     (time_load),
      .load_val (time_val[`ROC_TIME_MIN_LSB +: 6]),
      .value    (min),
      .wrap     (min_wrap)
   );

   roc_count #(.W(5), .LAST(5'h17)) u_hour (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .step     (min_wrap),
      .load     (time_load),
      .load_val (time_val[`ROC_TIME_HOUR_LSB +: 5]),
      .value    (hour),
      .wrap     ()
   );

   // correction schedule, evaluated one cycle after a minute boundary
   wire [7:0] off_mag  = offset[6] ? (8'h00 - {1'b1, offset}) : {1'b0, offset};
   wire       trigger  = new_minute && (min == 6'h00) && (coarse || !hour[0]);
   wire [6:0] rem_src  = trigger ? off_mag[6:0] | {off_mag[7], 6'h00} : corr_left;
   wire       last_min = (min == `ROC_LAST_MINUTE);
   // coarse dumps the remainder into the last minute; otherwise one per minute
   wire [6:0] burst    = (coarse && last_min) ? rem_src
                         : {6'h00, (rem_src != 7'h00)};

   always @(posedge aclk) begin
      if (!aresetn) begin
         new_minute     <= 1'b0;
         corr_left      <= 7'h00;
         burst_left     <= 7'h00;
         corr_neg       <= 1'b0;
         corr_sign_pend <= 1'b0;
      end else begin
         new_minute <= sec_wrap;
         if (trigger) begin
            corr_sign_pend <= offset[6];
         end
         if (new_minute) begin
            corr_left  <= rem_src - burst;
            burst_left <= burst;
            corr_neg   <= trigger ? offset[6] : corr_sign_pend;
         end else if (corr_apply) begin
            burst_left <= burst_left - 7'h01;
         end
      end
   end

   // correction monitor pulse: 1/128 s wide; repeats fall on 1/64 s steps
   reg [31:0] mon_cnt;
   reg        mon_on;

   always @(posedge aclk) begin
      if (!aresetn) begin
         mon_cnt <= 32'h0000_0000;
         mon_on  <= 1'b0;
      end else if (corr_apply && correction_monitor_irq_enable) begin
         mon_cnt <= 32'h0000_0000;
         mon_on  <= 1'b1;
      end else if (mon_on) begin
         if (mon_cnt == MON_LAST) begin
            mon_on <= 1'b0;
         end else begin
            mon_cnt <= mon_cnt + 32'h0000_0001;
         end
      end
   end

   // axi4-lite write side
   wire        wr_go = s_axi_awready && s_axi_wready;
   reg  [31:0] wmask;
   reg  [`ROC_ST_W-1:0] st_clr;

   always @* begin
      wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
               {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      st_clr = {`ROC_ST_W{1'b0}};
      if (wr_go && s_axi_awaddr == `ROC_REG_STATUS) begin
         st_clr = s_axi_wdata[`ROC_ST_W-1:0] & wmask[`ROC_ST_W-1:0];
      end
   end

   wire [31:0] time_now = {11'h000, hour, 2'b00, min, 2'b00, sec};

   always @* begin
      time_load = wr_go && (s_axi_awaddr == `ROC_REG_TIME);
      time_val  = (time_now & ~wmask) | (s_axi_wdata & wmask);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         ctrl          <= `ROC_CTRL_RST;
         offset        <= `ROC_OFFSET_RST;
         mask          <= `ROC_MASK_RST;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !wr_go;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            case (s_axi_awaddr)
               `ROC_REG_CTRL: begin
                  ctrl <= (ctrl & ~wmask[`ROC_CTRL_W-1:0])
                          | (s_axi_wdata[`ROC_CTRL_W-1:0] & wmask[`ROC_CTRL_W-1:0]);
               end
               `ROC_REG_OFFSET: begin
                  offset <= (offset & ~wmask[6:0]) | (s_axi_wdata[6:0] & wmask[6:0]);
               end
               `ROC_REG_MASK: begin
                  mask <= (mask & ~wmask[`ROC_ST_W-1:0])
                          | (s_axi_wdata[`ROC_ST_W-1:0] & wmask[`ROC_ST_W-1:0]);
               end
               `ROC_REG_TIME, `ROC_REG_STATUS: begin
                  s_axi_bresp <= 2'b00;
               end
               default: begin
                  s_axi_bresp <= 2'b10;
               end
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // sticky status: a set in the clearing cycle wins
   wire [`ROC_ST_W-1:0] st_set = {sec_wrap, sec_tick, corr_apply};

   always @(posedge aclk) begin
      if (!aresetn) begin
         status <= {`ROC_ST_W{1'b0}};
      end else begin
         status <= (status & ~st_clr) | st_set;
      end
   end

   // axi4-lite read side
   reg [31:0] rd_val;
   reg        rd_ok;

   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         `ROC_REG_CTRL:   rd_val = {28'h0000000, ctrl};
         `ROC_REG_OFFSET: rd_val = {25'h0000000, offset};
         `ROC_REG_TIME:   rd_val = time_now;
         `ROC_REG_STATUS: rd_val = {29'h00000000, status};
         `ROC_REG_MASK:   rd_val = {29'h00000000, mask};
         default:         rd_ok  = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // pin, tick and interrupt outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         clock_out_pin_o    <= 1'b0;
         clock_out_pin_oe_n <= 1'b1;
         tick_1hz           <= 1'b0;
         tick_64hz          <= 1'b0;
         irq                <= 1'b0;
      end else begin
         clock_out_pin_o    <= 1'b0;
         // open drain: pull low on the low half of the corrected 1 hz wave
         clock_out_pin_oe_n <= external_clock_test_select || presc[PW-1];
         tick_1hz           <= sec_tick;
         tick_64hz          <= base_en;
         irq                <= (|(status & mask)) || mon_on;
      end
   end

endmodule
